/* File: bench/aas_conv_model.sv */
// Behavioural converter: takes one request, later returns one reading
`timescale 1ns/100ps
module aas_conv_model #(
  parameter int LAT = 0
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_req,
  input  wire logic [7:0] i_value,
  output logic            o_ack,
  output logic            o_done,
  output logic [7:0]      o_data,
  output int              o_count
);
  logic [7:0] last;

  initial begin
    o_ack = 1'b0;
    o_done = 1'b0;
    o_data = 8'h00;
    o_count = 0;
    last = 8'hff;
    forever begin
      @(posedge i_clk_sys iff i_req === 1'b1);
      repeat (LAT) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      o_ack = 1'b1;
      @(negedge i_clk_sys);
      o_ack = 1'b0;
      // A slow converter also takes longer to deliver the reading
      repeat (LAT) @(negedge i_clk_sys);
      o_done = 1'b1;
      o_data = i_value;
      last = i_value;
      @(negedge i_clk_sys);
      o_done = 1'b0;
      // Stale data is inverted so the design cannot reuse it unnoticed
      o_data = ~last;
      o_count++;
    end
  end
endmodule

/* File: bench/aas_supply_monitor_tb_top.sv */
// Self-checking bench for the supply monitor converter control
`timescale 1ns/100ps
`define CHECK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module aas_supply_monitor_tb_top import aas_pkg::*;;
  logic       clk = 1'b0;
  logic       rst_n;
  logic [1:0] mode;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       bat_req, bat_ack, bat_done, ext_req, ext_ack, ext_done;
  logic [7:0] bat_data, ext_data, bat_val, ext_val;
  logic       psm_irq, bat_irq, ext_irq;
  int         bat_cnt, ext_cnt;
  int         n_bat_irq = 0;
  int         n_ext_irq = 0;
  int         n_errors = 0;
  int         cmp_count = 0;

  always #5 clk = ~clk;

  aas_supply_monitor #(.TICK_CYCLES(20)) i_aas_supply_monitor (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_power_mode(mode),
    .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
    .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
    .o_bat_req(bat_req), .i_bat_ack(bat_ack), .i_bat_done(bat_done),
    .i_bat_data(bat_data), .o_ext_req(ext_req), .i_ext_ack(ext_ack),
    .i_ext_done(ext_done), .i_ext_data(ext_data), .o_psm_irq(psm_irq),
    .o_bat_adc_irq(bat_irq), .o_ext_adc_irq(ext_irq));

  // Battery side answers at once, external side slowly
  aas_conv_model #(.LAT(0)) i_aas_conv_model_bat (
    .i_clk_sys(clk), .i_req(bat_req), .i_value(bat_val), .o_ack(bat_ack),
    .o_done(bat_done), .o_data(bat_data), .o_count(bat_cnt));
  aas_conv_model #(.LAT(4)) i_aas_conv_model_ext (
    .i_clk_sys(clk), .i_req(ext_req), .i_value(ext_val), .o_ack(ext_ack),
    .o_done(ext_done), .o_data(ext_data), .o_count(ext_cnt));

  always @(posedge clk) begin
    if (bat_irq === 1'b1) n_bat_irq++;
    if (ext_irq === 1'b1) n_ext_irq++;
  end

  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CHECK($sformatf("register %h", a), exp, sfr_rdata)
  endtask

  function automatic int cnt(input bit ext);
    return ext ? ext_cnt : bat_cnt;
  endfunction

  // Bounded wait for a finished conversion, then let the result land
  task automatic wait_conv(input bit ext, input int prev);
    for (int i = 0; i < 300 && cnt(ext) <= prev; i++) @(negedge clk);
    `CHECK("conversion finished", 1'b1, cnt(ext) > prev)
    repeat (4) @(negedge clk);
  endtask

  task automatic no_conv(input bit ext);
    int c;
    c = cnt(ext);
    repeat (100) @(negedge clk);
    `CHECK("conversion count", c, cnt(ext))
  endtask

  task automatic t_reset;
    logic [7:0] regs [9] = '{ADDR_CONV_START, ADDR_BAT_RESULT,
      ADDR_IRQ_ENABLE, ADDR_EXT_RESULT, ADDR_DELTA_CFG, ADDR_IRQ_FLAGS,
      ADDR_INTERVAL, ADDR_BAT_THRESH, 8'h10};
    no_conv(1);
    foreach (regs[i]) reg_rd(regs[i], REG_RESET);
    reg_wr(ADDR_BAT_RESULT, 8'hff);
    reg_rd(ADDR_BAT_RESULT, REG_RESET);
  endtask

  task automatic t_bat_single;
    int c, b0;
    mode = MODE_FULL_ACTIVE;
    bat_val = 8'h5a;
    reg_wr(ADDR_IRQ_ENABLE, 8'h04);
    b0 = n_bat_irq;
    c = bat_cnt;
    reg_wr(ADDR_CONV_START, 8'h01);
    reg_rd(ADDR_CONV_START, 8'h01);
    wait_conv(0, c);
    reg_rd(ADDR_CONV_START, 8'h00);
    reg_rd(ADDR_BAT_RESULT, 8'h5a);
    reg_rd(ADDR_IRQ_FLAGS, 8'h04);
    `CHECK("battery irq count", b0 + 1, n_bat_irq)
    `CHECK("psm irq", 1'b1, psm_irq)
    reg_wr(ADDR_IRQ_FLAGS, 8'h04);
    reg_rd(ADDR_IRQ_FLAGS, 8'h00);
    `CHECK("psm irq", 1'b0, psm_irq)
  endtask

  task automatic t_bat_modes;
    int c, b0;
    mode = MODE_BATT_ACTIVE;
    bat_val = 8'h33;
    c = bat_cnt;
    reg_wr(ADDR_CONV_START, 8'h01);
    wait_conv(0, c);
    reg_rd(ADDR_BAT_RESULT, 8'h33);
    reg_wr(ADDR_IRQ_FLAGS, 8'h04);
    // Sleep and the unused code must both drop a start request
    for (int m = 2; m < 4; m++) begin
      mode = m[1:0];
      b0 = n_bat_irq;
      bat_val = 8'h77;
      reg_wr(ADDR_CONV_START, 8'h01);
      no_conv(0);
      reg_rd(ADDR_CONV_START, 8'h00);
      `CHECK("battery irq count", b0, n_bat_irq)
    end
    reg_rd(ADDR_BAT_RESULT, 8'h33);
    reg_wr(ADDR_INTERVAL, 8'h01);
    mode = MODE_BATT_ACTIVE;
    no_conv(0);
    mode = MODE_SLEEP_HALTED;
    no_conv(0);
    reg_wr(ADDR_BAT_THRESH, 8'h40);
    bat_val = 8'h50;
    c = bat_cnt;
    mode = MODE_FULL_ACTIVE;
    wait_conv(0, c);
    `CHECK("background ran", 1'b1, bat_cnt > c)
    reg_rd(ADDR_BAT_RESULT, 8'h33);
    reg_rd(ADDR_IRQ_FLAGS, 8'h00);
    b0 = n_bat_irq;
    bat_val = 8'h30;
    c = bat_cnt;
    wait_conv(0, c);
    `CHECK("battery irq count", b0 + 1, n_bat_irq)
    reg_rd(ADDR_BAT_RESULT, 8'h30);
    reg_rd(ADDR_IRQ_FLAGS, 8'h04);
    `CHECK("psm irq", 1'b1, psm_irq)
    reg_wr(ADDR_INTERVAL, 8'h00);
    repeat (30) @(negedge clk);
    reg_wr(ADDR_IRQ_FLAGS, 8'h04);
  endtask

  task automatic t_ext_single;
    int c, e0;
    mode = MODE_SLEEP_HALTED;
    ext_val = 8'h80;
    e0 = n_ext_irq;
    reg_wr(ADDR_CONV_START, 8'h04);
    no_conv(1);
    `CHECK("ext irq count", e0, n_ext_irq)
    mode = MODE_BATT_ACTIVE;
    c = ext_cnt;
    reg_wr(ADDR_CONV_START, 8'h04);
    wait_conv(1, c);
    `CHECK("ext irq count", e0 + 1, n_ext_irq)
    mode = MODE_FULL_ACTIVE;
    c = ext_cnt;
    reg_wr(ADDR_CONV_START, 8'h04);
    wait_conv(1, c);
    `CHECK("ext irq count", e0 + 2, n_ext_irq)
    reg_rd(ADDR_EXT_RESULT, 8'h80);
    reg_rd(ADDR_IRQ_FLAGS, 8'h00);
  endtask

  task automatic t_ext_bg;
    int c, e0;
    reg_wr(ADDR_IRQ_ENABLE, 8'h00);
    // Delta before interval, after the single conversion
    reg_wr(ADDR_DELTA_CFG, 8'h02);
    ext_val = 8'h82;
    c = ext_cnt;
    e0 = n_ext_irq;
    reg_wr(ADDR_INTERVAL, 8'h04);
    wait_conv(1, c);
    `CHECK("ext irq count", e0, n_ext_irq)
    reg_rd(ADDR_EXT_RESULT, 8'h80);
    ext_val = 8'h83;
    c = ext_cnt;
    wait_conv(1, c);
    `CHECK("ext irq count", e0 + 1, n_ext_irq)
    reg_rd(ADDR_EXT_RESULT, 8'h83);
    reg_rd(ADDR_IRQ_FLAGS, 8'h08);
    `CHECK("psm irq", 1'b0, psm_irq)
    reg_wr(ADDR_IRQ_ENABLE, 8'h08);
    reg_rd(ADDR_IRQ_ENABLE, 8'h08);
    `CHECK("psm irq", 1'b1, psm_irq)
    reg_wr(ADDR_IRQ_FLAGS, 8'h08);
    ext_val = 8'h81;
    c = ext_cnt;
    wait_conv(1, c);
    `CHECK("ext irq count", e0 + 1, n_ext_irq)
    reg_rd(ADDR_IRQ_FLAGS, 8'h00);
    ext_val = 8'h7f;
    c = ext_cnt;
    wait_conv(1, c);
    `CHECK("ext irq count", e0 + 2, n_ext_irq)
    reg_rd(ADDR_EXT_RESULT, 8'h7f);
    mode = MODE_BATT_ACTIVE;
    no_conv(1);
    mode = MODE_SLEEP_HALTED;
    c = ext_cnt;
    wait_conv(1, c);
    `CHECK("background ran", 1'b1, ext_cnt > c)
    reg_wr(ADDR_INTERVAL, 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    mode = MODE_FULL_ACTIVE;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    bat_val = 8'h00;
    ext_val = 8'h00;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_bat_single();
    t_bat_modes();
    t_ext_single();
    t_ext_bg();
    end_sim();
  end

  // The tests need about a thousand cycles; this margin catches a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule

/* File: common/aas_pkg.sv */
// Constants and types shared by the supply monitor converter control
package aas_pkg;

  // Register byte addresses on the special function register bus
  localparam logic [7:0] ADDR_CONV_START = 8'hd8;
  localparam logic [7:0] ADDR_BAT_RESULT = 8'hdf;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hec;
  localparam logic [7:0] ADDR_EXT_RESULT = 8'hef;
  localparam logic [7:0] ADDR_DELTA_CFG  = 8'hf3;
  localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'hf8;
  localparam logic [7:0] ADDR_INTERVAL   = 8'hf9;
  localparam logic [7:0] ADDR_BAT_THRESH = 8'hfa;

  // Field positions
  localparam int BIT_BAT_START    = 0;
  localparam int BIT_EXT_START    = 2;
  localparam int BIT_BAT_FLAG     = 2;
  localparam int BIT_EXT_FLAG     = 3;
  localparam int DELTA_LSB        = 0;
  localparam int DELTA_W          = 3;
  localparam int INTV_BAT_LSB     = 0;
  localparam int INTV_EXT_LSB     = 2;
  localparam int INTV_W           = 2;

  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Result scaling in microvolts per count (informative for software)
  localparam int BAT_UV_PER_LSB = 14600;
  localparam int EXT_UV_PER_LSB = 15300;

  // Background interval base tick
  localparam int CLK_MHZ          = 100;
  localparam int TICK_US          = 1000;
  localparam int TICK_CYCLES_DEF  = TICK_US * CLK_MHZ;

  typedef enum logic [1:0] {
    MODE_FULL_ACTIVE  = 2'b00,
    MODE_BATT_ACTIVE  = 2'b01,
    MODE_SLEEP_HALTED = 2'b10
  } aas_mode_t;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_REQ  = 2'b01,
    CH_WAIT = 2'b10
  } aas_ch_state_t;

endpackage

/* File: hw/aas_chan.sv */
// One converter channel: start latch, background timer, request handshake
`timescale 1ns/100ps
module aas_chan import aas_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_go,
  input  wire logic        i_single_ok,
  input  wire logic        i_bg_ok,
  input  wire logic [1:0]  i_bg_code,
  input  wire logic        i_ack,
  input  wire logic        i_done,
  input  wire logic [7:0]  i_data,
  output logic             o_pend,
  output logic             o_req,
  output logic             o_done,
  output logic             o_single,
  output logic [7:0]       o_data
);
  aas_ch_state_t state;
  aas_ch_state_t next_state;
  logic [31:0]   cnt;
  logic [31:0]   next_cnt;
  logic [31:0]   limit;
  logic          due;
  logic          next_due;
  logic          next_pend;
  logic          next_done;
  logic          next_single;
  logic [7:0]    next_data;
  logic          next_req;
  logic          bg_on;

  // Interval doubles per code step; code 0 keeps background off
  assign bg_on = (i_bg_code != 2'b00) && i_bg_ok;
  assign limit = 32'(TICK_CYCLES) << (i_bg_code - 2'b01);

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_due    = due;
    next_pend   = o_pend;
    next_done   = 1'b0;
    next_single = o_single;
    next_data   = o_data;
    if (!bg_on) begin
      next_cnt = 32'h0;
      next_due = 1'b0;
    end else if (cnt + 32'h1 >= limit) begin
      next_cnt = 32'h0;
      next_due = 1'b1;
    end else begin
      next_cnt = cnt + 32'h1;
    end
    case (state)
      CH_IDLE: begin
        if (o_pend && i_single_ok) begin
          next_state  = CH_REQ;
          next_single = 1'b1;
        end else if (o_pend) begin
          next_pend = 1'b0;
        end else if (due && bg_on) begin
          next_state  = CH_REQ;
          next_single = 1'b0;
          next_due    = 1'b0;
        end
      end
      CH_REQ: begin
        if (i_ack) begin
          next_state = CH_WAIT;
          if (o_single) begin
            next_pend = 1'b0;
          end
        end
      end
      CH_WAIT: begin
        if (i_done) begin
          next_state = CH_IDLE;
          next_done  = 1'b1;
          next_data  = i_data;
        end
      end
      default: begin
        next_state = CH_IDLE;
      end
    endcase
    // A fresh start written in the clearing cycle is kept
    if (i_go) begin
      next_pend = 1'b1;
    end
    // Request is a register so the top output comes from a flip-flop
    next_req = (next_state == CH_REQ);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= CH_IDLE;
      cnt      <= 32'h0;
      due      <= 1'b0;
      o_pend   <= 1'b0;
      o_req    <= 1'b0;
      o_done   <= 1'b0;
      o_single <= 1'b0;
      o_data   <= 8'h00;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      due      <= next_due;
      o_pend   <= next_pend;
      o_req    <= next_req;
      o_done   <= next_done;
      o_single <= next_single;
      o_data   <= next_data;
    end
  end

  property p_pend_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_req && i_ack && o_single && !i_go) |=> !o_pend;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("start bit not cleared on accept");

  property p_ignore;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == CH_IDLE && o_pend && !i_single_ok && !i_go)
        |=> (!o_pend && !o_req);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("unavailable start not dropped");

  property p_bg_off;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == CH_IDLE && !o_pend && i_bg_code == 2'b00) |=> !o_req;
  endproperty
  a_bg_off: assert property (p_bg_off)
    else $error("background conversion with interval zero");
endmodule

/* File: hw/aas_supply_monitor.sv */
// Battery and external voltage converter control with its registers
`timescale 1ns/100ps
module aas_supply_monitor import aas_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic [1:0]  i_power_mode,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic [7:0]       o_sfr_rdata,
  output logic             o_bat_req,
  input  wire logic        i_bat_ack,
  input  wire logic        i_bat_done,
  input  wire logic [7:0]  i_bat_data,
  output logic             o_ext_req,
  input  wire logic        i_ext_ack,
  input  wire logic        i_ext_done,
  input  wire logic [7:0]  i_ext_data,
  output logic             o_psm_irq,
  output logic             o_bat_adc_irq,
  output logic             o_ext_adc_irq
);
  logic [7:0] irq_enable;
  logic [7:0] delta_cfg;
  logic [7:0] interval;
  logic [7:0] bat_thresh;
  logic [7:0] bat_result;
  logic [7:0] ext_result;
  logic [7:0] ext_ref;
  logic       bat_flag;
  logic       ext_flag;
  logic [7:0] next_irq_enable;
  logic [7:0] next_delta_cfg;
  logic [7:0] next_interval;
  logic [7:0] next_bat_thresh;
  logic [7:0] next_bat_result;
  logic [7:0] next_ext_result;
  logic [7:0] next_ext_ref;
  logic       next_bat_flag;
  logic       next_ext_flag;
  logic [7:0] next_rdata;
  logic       next_psm_irq;
  logic       next_bat_irq;
  logic       next_ext_irq;

  logic       bat_single_ok;
  logic       bat_bg_ok;
  logic       ext_single_ok;
  logic       ext_bg_ok;
  logic       wr_start;
  logic       wr_flags;
  logic       bat_go;
  logic       ext_go;
  logic       bat_pend;
  logic       ext_pend;
  logic       bat_done;
  logic       ext_done;
  logic       bat_single;
  logic       ext_single;
  logic [7:0] bat_data;
  logic [7:0] ext_data;
  logic       bat_hit;
  logic [7:0] ext_diff;
  logic       ext_exceed;
  logic       ext_hit;
  logic       ext_bg_exceed;

  // Mode gating of single starts and background runs
  always_comb begin
    bat_single_ok = 1'b0;
    bat_bg_ok     = 1'b0;
    ext_single_ok = 1'b0;
    ext_bg_ok     = 1'b0;
    case (i_power_mode)
      MODE_FULL_ACTIVE: begin
        bat_single_ok = 1'b1;
        bat_bg_ok     = 1'b1;
        ext_single_ok = 1'b1;
        ext_bg_ok     = 1'b1;
      end
      MODE_BATT_ACTIVE: begin
        bat_single_ok = 1'b1;
        ext_single_ok = 1'b1;
      end
      MODE_SLEEP_HALTED: begin
        ext_bg_ok     = 1'b1;
        bat_bg_ok     = 1'b0;
      end
      // Undefined mode codes run nothing, unlike sleep which keeps external background runs
      default: begin
        bat_single_ok = 1'b0;
      end
    endcase
  end

  assign wr_start = i_sfr_wr && (i_sfr_addr == ADDR_CONV_START);
  assign wr_flags = i_sfr_wr && (i_sfr_addr == ADDR_IRQ_FLAGS);
  assign bat_go   = wr_start && i_sfr_wdata[BIT_BAT_START];
  assign ext_go   = wr_start && i_sfr_wdata[BIT_EXT_START];

  aas_chan #(.TICK_CYCLES(TICK_CYCLES)) u_bat_chan (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_go        (bat_go),
    .i_single_ok (bat_single_ok),
    .i_bg_ok     (bat_bg_ok),
    .i_bg_code   (interval[INTV_BAT_LSB +: INTV_W]),
    .i_ack       (i_bat_ack),
    .i_done      (i_bat_done),
    .i_data      (i_bat_data),
    .o_pend      (bat_pend),
    .o_req       (o_bat_req),
    .o_done      (bat_done),
    .o_single    (bat_single),
    .o_data      (bat_data)
  );

  aas_chan #(.TICK_CYCLES(TICK_CYCLES)) u_ext_chan (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_go        (ext_go),
    .i_single_ok (ext_single_ok),
    .i_bg_ok     (ext_bg_ok),
    .i_bg_code   (interval[INTV_EXT_LSB +: INTV_W]),
    .i_ack       (i_ext_ack),
    .i_done      (i_ext_done),
    .i_data      (i_ext_data),
    .o_pend      (ext_pend),
    .o_req       (o_ext_req),
    .o_done      (ext_done),
    .o_single    (ext_single),
    .o_data      (ext_data)
  );

  // Battery: low reading or finished single start counts as a hit
  assign bat_hit = bat_done && (bat_single || (bat_data < bat_thresh));

  // External: distance from the last reading that interrupted
  assign ext_diff   = (ext_data > ext_ref) ? (ext_data - ext_ref)
                                           : (ext_ref - ext_data);
  assign ext_exceed = ext_diff > {5'b0_0000, delta_cfg[DELTA_LSB +: DELTA_W]};
  assign ext_bg_exceed = ext_done && !ext_single && ext_exceed;
  assign ext_hit    = ext_bg_exceed || (ext_done && ext_single);

  always_comb begin
    next_irq_enable = irq_enable;
    next_delta_cfg  = delta_cfg;
    next_interval   = interval;
    next_bat_thresh = bat_thresh;
    next_bat_result = bat_result;
    next_ext_result = ext_result;
    next_ext_ref    = ext_ref;
    next_bat_flag   = bat_flag;
    next_ext_flag   = ext_flag;
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        ADDR_IRQ_ENABLE: next_irq_enable = i_sfr_wdata;
        ADDR_DELTA_CFG:  next_delta_cfg  = i_sfr_wdata;
        ADDR_INTERVAL:   next_interval   = i_sfr_wdata;
        ADDR_BAT_THRESH: next_bat_thresh = i_sfr_wdata;
        default:         next_interval   = interval;
      endcase
    end
    // Flags clear by writing one; a same-cycle event still sets them
    if (wr_flags && i_sfr_wdata[BIT_BAT_FLAG]) begin
      next_bat_flag = 1'b0;
    end
    if (wr_flags && i_sfr_wdata[BIT_EXT_FLAG]) begin
      next_ext_flag = 1'b0;
    end
    if (bat_hit) begin
      next_bat_flag   = 1'b1;
      next_bat_result = bat_data;
    end
    if (ext_bg_exceed) begin
      next_ext_flag = 1'b1;
    end
    if (ext_hit) begin
      next_ext_result = ext_data;
      next_ext_ref    = ext_data;
    end
  end

  // Interrupt lines and read data
  always_comb begin
    next_psm_irq = (bat_flag && irq_enable[BIT_BAT_FLAG]) ||
                   (ext_flag && irq_enable[BIT_EXT_FLAG]);
    next_bat_irq = bat_hit;
    next_ext_irq = ext_hit;
    next_rdata   = 8'h00;
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        ADDR_CONV_START: begin
          next_rdata[BIT_BAT_START] = bat_pend;
          next_rdata[BIT_EXT_START] = ext_pend;
        end
        ADDR_BAT_RESULT: next_rdata = bat_result;
        ADDR_IRQ_ENABLE: next_rdata = irq_enable;
        ADDR_EXT_RESULT: next_rdata = ext_result;
        ADDR_DELTA_CFG:  next_rdata = delta_cfg;
        ADDR_IRQ_FLAGS: begin
          next_rdata[BIT_BAT_FLAG] = bat_flag;
          next_rdata[BIT_EXT_FLAG] = ext_flag;
        end
        ADDR_INTERVAL:   next_rdata = interval;
        ADDR_BAT_THRESH: next_rdata = bat_thresh;
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_enable    <= REG_RESET;
      delta_cfg     <= REG_RESET;
      interval      <= REG_RESET;
      bat_thresh    <= REG_RESET;
      bat_result    <= REG_RESET;
      ext_result    <= REG_RESET;
      ext_ref       <= REG_RESET;
      bat_flag      <= 1'b0;
      ext_flag      <= 1'b0;
      o_sfr_rdata   <= REG_RESET;
      o_psm_irq     <= 1'b0;
      o_bat_adc_irq <= 1'b0;
      o_ext_adc_irq <= 1'b0;
    end else begin
      irq_enable    <= next_irq_enable;
      delta_cfg     <= next_delta_cfg;
      interval      <= next_interval;
      bat_thresh    <= next_bat_thresh;
      bat_result    <= next_bat_result;
      ext_result    <= next_ext_result;
      ext_ref       <= next_ext_ref;
      bat_flag      <= next_bat_flag;
      ext_flag      <= next_ext_flag;
      o_sfr_rdata   <= next_rdata;
      o_psm_irq     <= next_psm_irq;
      o_bat_adc_irq <= next_bat_irq;
      o_ext_adc_irq <= next_ext_irq;
    end
  end

  property p_bat_sleep;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_bat_req) |-> ($past(i_power_mode) != MODE_SLEEP_HALTED);
  endproperty
  a_bat_sleep: assert property (p_bat_sleep)
    else $error("battery conversion started in sleep");

  property p_bat_batt_mode;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      ($rose(o_bat_req) && $past(i_power_mode) == MODE_BATT_ACTIVE)
        |-> bat_single;
  endproperty
  a_bat_batt_mode: assert property (p_bat_batt_mode)
    else $error("background battery run in battery mode");

  property p_ext_batt_mode;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      ($rose(o_ext_req) && $past(i_power_mode) == MODE_BATT_ACTIVE)
        |-> ext_single;
  endproperty
  a_ext_batt_mode: assert property (p_ext_batt_mode)
    else $error("background external run in battery mode");

  property p_ext_sleep;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      ($rose(o_ext_req) && $past(i_power_mode) == MODE_SLEEP_HALTED)
        |-> !ext_single;
  endproperty
  a_ext_sleep: assert property (p_ext_sleep)
    else $error("single external start taken in sleep");

  property p_bat_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (bat_done && bat_data < bat_thresh)
        |=> (bat_flag && bat_result == $past(bat_data) && o_bat_adc_irq);
  endproperty
  a_bat_low: assert property (p_bat_low)
    else $error("low battery reading not flagged");

  property p_bat_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !bat_hit |=> $stable(bat_result);
  endproperty
  a_bat_hold: assert property (p_bat_hold)
    else $error("battery result changed without flag");

  property p_psm;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (bat_flag && irq_enable[BIT_BAT_FLAG]) |=> o_psm_irq;
  endproperty
  a_psm: assert property (p_psm)
    else $error("enabled battery flag missed power interrupt");

  property p_ext_mask;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (!bat_flag && !irq_enable[BIT_EXT_FLAG]) |=> !o_psm_irq;
  endproperty
  a_ext_mask: assert property (p_ext_mask)
    else $error("power interrupt without enabled source");

  property p_ext_delta;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      ext_bg_exceed |=> (ext_flag && o_ext_adc_irq &&
                         ext_result == $past(ext_data) &&
                         ext_ref == ext_result);
  endproperty
  a_ext_delta: assert property (p_ext_delta)
    else $error("external delta not flagged");

  property p_ext_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !ext_hit |=> ($stable(ext_result) && !o_ext_adc_irq);
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("external result changed without interrupt");
endmodule
